// ### src/mesf_event_status.sv
// Event status flags, mask, clearing read and open-drain interrupt
//
// Contract
// - Sag on phase A, B, C sets flags 3, 4, 5.
// - Missing zero crossing on phase A, B, C sets flags 6, 7, 8.
// - Rising zero crossing on phase A, B, C sets flags 9, 10, 11.
// - Line accumulation mode end of half-cycle integration sets flag 12.
// - Supply below 4 V reset event sets flag 13, default one.
// - Reset flag reads high in both views for only one cycle.
// - Reset event returns all registers to defaults; software may trigger it.
// - Selected voltage above peak threshold sets flag 14.
// - Selected current above peak threshold sets flag 15.
// - New waveform sample sets flag 16.
// - Active power sign change on a selected phase sets flag 17.
// - Reactive power sign change on a selected phase sets flag 18.
// - Phase A crossing followed by B instead of C sets flag 19.
// - Flags stay high until the clearing view is read, then return to default.
// - Interrupt pin pulled low only for flagged events with mask bit one.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mesf_event_status
  import mesf_pkg::*;
#(
  parameter int unsigned NFLAG = MESF_NFLAG
)(
  input  wire logic                       clock,          // System clock, 125 MHz
  input  wire logic                       rst,            // Async reset, active high
  input  wire logic                       clk_en,         // Freezes all state when low
  input  wire logic [mesf_pkg::MESF_AW-1:0] reg_addr,     // Register byte address
  input  wire logic [mesf_pkg::MESF_DW-1:0] reg_wdata,    // Write data
  input  wire logic                       reg_wr,         // Write strobe
  input  wire logic                       reg_rd,         // Read strobe
  output logic      [mesf_pkg::MESF_DW-1:0] reg_rdata,    // Read data, cycle after strobe
  input  wire logic                       supply_low,     // Supply below 4 V level
  input  wire logic [2:0]                 sag_evt,        // Sag per phase A,B,C
  input  wire logic [2:0]                 zx_timeout_evt, // Missing crossing per phase
  input  wire logic [2:0]                 zx_rise_evt,    // Rising crossing per phase
  input  wire logic                       line_accum_mode,// Line-cycle accumulation mode on
  input  wire logic                       half_cycle_done,// Programmed half cycles done
  input  wire logic                       v_above_peak,   // Selected voltage over threshold
  input  wire logic                       i_above_peak,   // Selected current over threshold
  input  wire logic                       wave_sample_new,// Waveform sample written
  input  wire logic [2:0]                 p_sign_flip,    // Active power sign change per phase
  input  wire logic [2:0]                 q_sign_flip,    // Reactive power sign change per phase
  output logic      [2:0]                 phase_term_select, // Configured phase terms
  output logic                            soft_reset_out, // Pulse to reset the rest of the chip
  output logic                            irq_n_o,        // Interrupt pin output value, always 0
  output logic                            irq_n_oe_n      // Pin enable, low while pulling low
);
  import mesf_pkg::*;

  logic [NFLAG-1:0] status_q;
  logic [NFLAG-1:0] mask_q;
  logic [2:0]       term_q;
  logic             supply_low_q;
  logic             reset_evt_q;
  logic             soft_rst_q;
  logic             seq_err;
  logic [NFLAG-1:0] events;
  logic             clr_rd;
  logic             rd_status;
  logic             wr_mask;
  logic             wr_cfg;
  logic             wr_swrst;
  logic             irq_d;

  function automatic logic hit(input logic [MESF_AW-1:0] a, input logic [MESF_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  assign clr_rd    = reg_rd && hit(reg_addr, MESF_OFF_CLEARING_STATUS_VIEW);
  assign rd_status = reg_rd && hit(reg_addr, MESF_OFF_STATUS);
  assign wr_mask   = reg_wr && hit(reg_addr, MESF_OFF_MASK);
  assign wr_cfg    = reg_wr && hit(reg_addr, MESF_OFF_CONFIG);
  assign wr_swrst  = reg_wr && hit(reg_addr, MESF_OFF_SWRST) && (reg_wdata == MESF_SWRST_KEY);

  mesf_seq_detect u_seq (
    .clock    (clock),
    .rst      (rst),
    .clk_en   (clk_en),
    .soft_rst (soft_rst_q),
    .zx_a     (zx_rise_evt[0]),
    .zx_b     (zx_rise_evt[1]),
    .zx_c     (zx_rise_evt[2]),
    .seq_err  (seq_err)
  );

  // Event vector in flag layout; bits below 3 stay zero here
  always_comb begin
    events                                  = '0;
    events[MESF_B_SAG  +: 3]                = sag_evt;
    events[MESF_B_ZXTO +: 3]                = zx_timeout_evt;
    events[MESF_B_ZX   +: 3]                = zx_rise_evt;
    events[MESF_B_LACC]                     = line_accum_mode && half_cycle_done;
    events[MESF_B_RESET]                    = reset_evt_q;
    events[MESF_B_PKV]                      = v_above_peak;
    events[MESF_B_PKI]                      = i_above_peak;
    events[MESF_B_WFS]                      = wave_sample_new;
    events[MESF_B_REVP]                     = |(p_sign_flip & term_q);
    events[MESF_B_REVQ]                     = |(q_sign_flip & term_q);
    events[MESF_B_SEQ]                      = seq_err;
  end

  // Supply drop edge becomes a reset event; a software key write does the same
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      supply_low_q <= 1'b0;
      reset_evt_q  <= 1'b0;
      soft_rst_q   <= 1'b0;
    end else if (clk_en) begin
      supply_low_q <= supply_low;
      reset_evt_q  <= (supply_low && !supply_low_q) || wr_swrst;
      soft_rst_q   <= (supply_low && !supply_low_q) || wr_swrst;
    end
  end

  // Sticky flags; set beats the clearing read. The reset flag is a one-cycle level.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_q <= MESF_STAT_RST[NFLAG-1:0];
    end else if (clk_en) begin
      if (soft_rst_q) begin
        status_q <= MESF_STAT_RST[NFLAG-1:0] | (events & MESF_EVT_MASK[NFLAG-1:0]);
      end else if (clr_rd) begin
        status_q <= events & MESF_EVT_MASK[NFLAG-1:0];
      end else begin
        status_q <= (status_q | events) & MESF_EVT_MASK[NFLAG-1:0];
      end
      // Reset flag must not stick past one cycle
      status_q[MESF_B_RESET] <= soft_rst_q || (reset_evt_q && !soft_rst_q);
    end
  end

  // Mask and config registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= MESF_MASK_RST[NFLAG-1:0];
      term_q <= MESF_TERM_RST;
    end else if (clk_en) begin
      if (soft_rst_q) begin
        mask_q <= MESF_MASK_RST[NFLAG-1:0];
        term_q <= MESF_TERM_RST;
      end else begin
        if (wr_mask) mask_q <= reg_wdata[NFLAG-1:0];
        if (wr_cfg)  term_q <= reg_wdata[MESF_TERM_LSB +: 3];
      end
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (rd_status || clr_rd) begin
        reg_rdata[NFLAG-1:0] <= status_q;
      end else if (reg_rd && hit(reg_addr, MESF_OFF_MASK)) begin
        reg_rdata[NFLAG-1:0] <= mask_q;
      end else if (reg_rd && hit(reg_addr, MESF_OFF_CONFIG)) begin
        reg_rdata[MESF_TERM_LSB +: 3] <= term_q;
      end
    end
  end

  // Interrupt follows the flags held now; the pin enable updates one edge later
  assign irq_d = |(mask_q & status_q & MESF_EVT_MASK[NFLAG-1:0]);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_n_oe_n        <= 1'b1;
      irq_n_o           <= 1'b0;
      phase_term_select <= MESF_TERM_RST;
      soft_reset_out    <= 1'b0;
    end else if (clk_en) begin
      irq_n_oe_n        <= !irq_d;
      irq_n_o           <= 1'b0;
      phase_term_select <= term_q;
      soft_reset_out    <= soft_rst_q;
    end
  end
endmodule : mesf_event_status
`default_nettype wire

// ### src/mesf_pkg.sv
// Package: register map, flag positions and reset values of the event status block
package mesf_pkg;
  localparam int unsigned   MESF_AW        = 8;
  localparam int unsigned   MESF_DW        = 32;
  localparam int unsigned   MESF_NFLAG     = 20;
  // Register word offsets (byte addresses)
  localparam logic [7:0]    MESF_OFF_MASK    = 8'h00;
  localparam logic [7:0]    MESF_OFF_STATUS  = 8'h04;
  localparam logic [7:0]    MESF_OFF_CLEARING_STATUS_VIEW = 8'h08;
  localparam logic [7:0]    MESF_OFF_CONFIG  = 8'h0c;
  localparam logic [7:0]    MESF_OFF_SWRST   = 8'h10;
  // Flag positions
  localparam int unsigned   MESF_B_SAG     = 3;
  localparam int unsigned   MESF_B_ZXTO    = 6;
  localparam int unsigned   MESF_B_ZX      = 9;
  localparam int unsigned   MESF_B_LACC    = 12;
  localparam int unsigned   MESF_B_RESET   = 13;
  localparam int unsigned   MESF_B_PKV     = 14;
  localparam int unsigned   MESF_B_PKI     = 15;
  localparam int unsigned   MESF_B_WFS     = 16;
  localparam int unsigned   MESF_B_REVP    = 17;
  localparam int unsigned   MESF_B_REVQ    = 18;
  localparam int unsigned   MESF_B_SEQ     = 19;
  localparam int unsigned   MESF_FIRST     = 3;
  // Config register fields: phase term select at bits 2:0
  localparam int unsigned   MESF_TERM_LSB  = 0;
  localparam logic [2:0]    MESF_TERM_RST  = 3'h7;
  // Reset values
  localparam logic [19:0]   MESF_STAT_RST  = 20'h02000;
  localparam logic [19:0]   MESF_MASK_RST  = 20'h00000;
  localparam logic [19:0]   MESF_EVT_MASK  = 20'hffff8;
  // Software reset key written to the soft reset register
  localparam logic [31:0]   MESF_SWRST_KEY = 32'h00000001;
  // Phase order tracker states
  typedef enum logic [2:0] {
    MESF_SEQ_IDLE  = 3'b001,
    MESF_SEQ_GOT_A = 3'b010,
    MESF_SEQ_OTHER = 3'b100
  } mesf_seq_t;
endpackage : mesf_pkg

// ### src/mesf_seq_detect.sv
// Phase order checker: flags A followed by B instead of C
`timescale 1ns/1ps
`default_nettype none
module mesf_seq_detect
  import mesf_pkg::*;
(
  input  wire logic clock,     // System clock
  input  wire logic rst,       // Async reset, active high
  input  wire logic clk_en,    // Freezes state when low
  input  wire logic soft_rst,  // Synchronous return to defaults
  input  wire logic zx_a,      // Phase A crossing pulse
  input  wire logic zx_b,      // Phase B crossing pulse
  input  wire logic zx_c,      // Phase C crossing pulse
  output logic      seq_err    // One-cycle order error pulse
);
  mesf_seq_t state_q;
  mesf_seq_t state_d;
  logic      err_d;

  always_comb begin
    state_d = state_q;
    err_d   = 1'b0;
    case (state_q)
      MESF_SEQ_IDLE: begin
        if (zx_a) state_d = MESF_SEQ_GOT_A;
      end
      MESF_SEQ_GOT_A: begin
        // Only the crossing right after A decides; simultaneous B and C count as C
        if (zx_c) begin
          state_d = zx_a ? MESF_SEQ_GOT_A : MESF_SEQ_OTHER;
        end else if (zx_b) begin
          err_d   = 1'b1;
          state_d = zx_a ? MESF_SEQ_GOT_A : MESF_SEQ_OTHER;
        end
      end
      MESF_SEQ_OTHER: begin
        if (zx_a) state_d = MESF_SEQ_GOT_A;
      end
      default: state_d = MESF_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= MESF_SEQ_IDLE;
      seq_err <= 1'b0;
    end else if (clk_en) begin
      if (soft_rst) begin
        state_q <= MESF_SEQ_IDLE;
        seq_err <= 1'b0;
      end else begin
        state_q <= state_d;
        seq_err <= err_d;
      end
    end
  end
endmodule : mesf_seq_detect
`default_nettype wire

// ### verif/mesf_event_status_chk.sv
// Checker: port-level properties of the event status block
`timescale 1ns/1ps
`default_nettype none
module mesf_event_status_chk
  import mesf_pkg::*;
(
  input wire logic        clock,             // Clock
  input wire logic        rst,               // Reset
  input wire logic        clk_en,            // Run enable
  input wire logic [7:0]  reg_addr,          // Address
  input wire logic        reg_rd,            // Read strobe
  input wire logic [31:0] reg_rdata,         // Read data
  input wire logic [2:0]  sag_evt,           // Sag events
  input wire logic        supply_low,        // Supply low
  input wire logic [2:0]  phase_term_select, // Term select
  input wire logic        soft_reset_out,    // Reset pulse
  input wire logic        irq_n_o,           // Pin value
  input wire logic        irq_n_oe_n         // Pin enable
);
  default clocking @(posedge clock); endclocking
  // Frozen cycles are not judged
  default disable iff (rst || !clk_en);
  AST_PIN_LOW: assert property (irq_n_o == 1'b0) else $error("irq pin value high");
  AST_IDLE_ZERO: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("rdata not zero");
  AST_HIGH_ZERO: assert property (reg_rd && reg_addr == MESF_OFF_STATUS |=> reg_rdata[31:20] == 12'h0)
    else $error("status upper bits set");
  AST_SAG_SEEN: assert property (reg_rd && reg_addr == MESF_OFF_STATUS && !$past(rst)
    |=> (reg_rdata[5:3] | ~$past(sag_evt, 2)) == 3'h7) else $error("sag flag missing");
  AST_RESET_PULSE: assert property ($rose(supply_low) |-> ##2 soft_reset_out ##1 !soft_reset_out)
    else $error("reset pulse wrong");
  AST_TERM_DEFAULT: assert property (soft_reset_out |=> phase_term_select == 3'h7) else $error("term");
  AST_IRQ_OFF: assert property (soft_reset_out |=> irq_n_oe_n) else $error("irq after reset");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata == 32'h0) else $error("unmapped");
  COV_CLEAR: cover property (reg_rd && reg_addr == MESF_OFF_CLEARING_STATUS_VIEW);
  COV_IRQ: cover property ($fell(irq_n_oe_n));
  COV_RESET: cover property (soft_reset_out);
endmodule : mesf_event_status_chk
`default_nettype wire

// ### verif/mesf_event_status_tb_top.sv
// Testbench: directed scenarios for the event status block
`timescale 1ns/1ps
`default_nettype none
module mesf_event_status_tb_top;
  import mesf_pkg::*;
  localparam logic [7:0] ST = MESF_OFF_STATUS;
  localparam logic [7:0] RS = MESF_OFF_CLEARING_STATUS_VIEW;
  logic        clock = 1'b0, rst = 1'b1, supply = 1'b0, lam = 1'b1, ce = 1'b1;
  logic [19:0] ev = '0;
  logic [2:0]  pf = '0, qf = '0, term;
  logic [7:0]  addr;
  logic [31:0] wd, rdat, d;
  logic        wr, rd, irq_o, irq_oe_n, irq_line, srst;
  int          errors = 0, tests_run = 0;
  always #4 clock = ~clock;
  mesf_event_status dut_u (.clock(clock), .rst(rst), .clk_en(ce), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .supply_low(supply), .sag_evt(ev[5:3]), .zx_timeout_evt(ev[8:6]),
    .zx_rise_evt(ev[11:9]), .line_accum_mode(lam), .half_cycle_done(ev[12]), .v_above_peak(ev[14]),
    .i_above_peak(ev[15]), .wave_sample_new(ev[16]), .p_sign_flip(pf), .q_sign_flip(qf),
    .phase_term_select(term), .soft_reset_out(srst), .irq_n_o(irq_o), .irq_n_oe_n(irq_oe_n));
  mesf_host_model host_u (.clock(clock), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdat), .irq_n_o(irq_o), .irq_n_oe_n(irq_oe_n), .irq_line(irq_line));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk
  task automatic pulse(input logic [19:0] v, input logic [2:0] p, input logic [2:0] q);
    ev <= v; pf <= p; qf <= q;
    @(posedge clock);
    ev <= '0; pf <= '0; qf <= '0;
    @(posedge clock);
  endtask : pulse
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    host_u.rd(a, d);
    chk(n, e, d);
  endtask : rchk
  // Pin is looked at mid-cycle so edge updates have landed
  task automatic pin(input logic e);
    @(negedge clock);
    chk("irq", {31'h0, e}, {31'h0, irq_line});
    @(posedge clock);
  endtask : pin
  task automatic stop_test;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic t_flags;
    for (int b = 3; b < 19; b++) begin
      if (b != 13 && (b < 9 || b > 11)) begin
        pulse(b < 17 ? 20'h1 << b : 20'h0, {2'b0, b == 17}, {2'b0, b == 18});
        rchk("flag", ST, 32'h1 << b);
        rchk("clear view", RS, 32'h1 << b);
        rchk("cleared", ST, 32'h0);
      end
    end
  endtask : t_flags
  task automatic t_seq;
    pulse(20'h200, 3'h0, 3'h0);
    pulse(20'h800, 3'h0, 3'h0);
    pulse(20'h400, 3'h0, 3'h0);
    rchk("order ok", RS, 32'he00);
    pulse(20'h200, 3'h0, 3'h0);
    pulse(20'h400, 3'h0, 3'h0);
    @(posedge clock);
    rchk("order bad", RS, 32'h80600);
  endtask : t_seq
  task automatic t_gate;
    host_u.wr(MESF_OFF_CONFIG, 32'h1);
    // The pin copy of the config lands one edge after the register
    @(posedge clock);
    chk("term", 32'h1, {29'h0, term});
    pulse(20'h0, 3'h6, 3'h6);
    lam <= 1'b0;
    pulse(20'h1000, 3'h0, 3'h0);
    rchk("unselected", RS, 32'h0);
    lam <= 1'b1;
    pulse(20'h0, 3'h1, 3'h0);
    rchk("selected", RS, 32'h20000);
    host_u.wr(MESF_OFF_CONFIG, 32'h7);
  endtask : t_gate
  task automatic t_irq;
    host_u.wr(MESF_OFF_MASK, 32'h8);
    pulse(20'h10, 3'h0, 3'h0);
    pin(1'b1);
    pulse(20'h8, 3'h0, 3'h0);
    pin(1'b0);
    rchk("source", ST, 32'h18);
    pin(1'b0);
    rchk("clear", RS, 32'h18);
    pin(1'b1);
    ev <= 20'h20;
    fork
      host_u.rd(RS, d);
      begin @(posedge clock); ev <= '0; end
    join
    chk("clear with event", 32'h0, d);
    rchk("kept", RS, 32'h20);
  endtask : t_irq
  task automatic t_soft;
    host_u.wr(MESF_OFF_MASK, 32'hfffff);
    host_u.wr(MESF_OFF_CONFIG, 32'h2);
    pulse(20'h10, 3'h0, 3'h0);
    host_u.wr(MESF_OFF_SWRST, 32'h2);
    rchk("bad key", MESF_OFF_MASK, 32'hfffff);
    pin(1'b0);
    host_u.wr(MESF_OFF_SWRST, MESF_SWRST_KEY);
    rchk("reset view", RS, 32'h2000);
    rchk("soft mask", MESF_OFF_MASK, 32'h0);
    chk("soft term", 32'h7, {29'h0, term});
    pin(1'b1);
    host_u.wr(MESF_OFF_MASK, 32'h8);
    supply <= 1'b1;
    repeat (2) @(posedge clock);
    rchk("supply flag", ST, 32'h2000);
    rchk("supply mask", MESF_OFF_MASK, 32'h0);
    rchk("one cycle", RS, 32'h0);
    supply <= 1'b0;
    host_u.wr(8'h14, 32'hffffffff);
    rchk("unmapped", 8'h14, 32'h0);
  endtask : t_soft
  // Frozen cycles must drop events; an unfrozen sag shows in a read one cycle later
  task automatic t_edge;
    ce <= 1'b0;
    pulse(20'h8, 3'h0, 3'h0);
    ce <= 1'b1;
    rchk("frozen", ST, 32'h0);
    fork
      pulse(20'h8, 3'h0, 3'h0);
      begin @(posedge clock); host_u.rd(ST, d); end
    join
    chk("sag at once", 32'h8, d);
    rchk("sag clear", RS, 32'h8);
  endtask : t_edge
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rchk("reset status", ST, 32'h2000);
    rchk("bit13 gone", RS, 32'h0);
    rchk("mask reset", MESF_OFF_MASK, 32'h0);
    chk("term reset", 32'h7, {29'h0, term});
    t_flags;
    t_seq;
    t_gate;
    t_irq;
    t_soft;
    t_edge;
    stop_test;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    stop_test;
  end
endmodule : mesf_event_status_tb_top
bind mesf_event_status mesf_event_status_chk chk_u (.clock(clock), .rst(rst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sag_evt(sag_evt), .supply_low(supply_low),
  .phase_term_select(phase_term_select), .soft_reset_out(soft_reset_out), .irq_n_o(irq_n_o),
  .irq_n_oe_n(irq_n_oe_n));
`default_nettype wire

// ### verif/mesf_host_model.sv
// Host model: register bus master and pulled-up interrupt line
`timescale 1ns/1ps
`default_nettype none
module mesf_host_model (
  input  wire logic        clock,      // Clock
  output var  logic [7:0]  reg_addr,   // Address
  output var  logic [31:0] reg_wdata,  // Write data
  output var  logic        reg_wr,     // Write strobe
  output var  logic        reg_rd,     // Read strobe
  input  wire logic [31:0] reg_rdata,  // Read data
  input  wire logic        irq_n_o,    // Pin value
  input  wire logic        irq_n_oe_n, // Pin enable
  output wire logic        irq_line    // Line level
);
  // External pull-up holds the line high while released
  assign irq_line = irq_n_oe_n ? 1'b1 : irq_n_o;
  initial begin
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  // Read task strobes one cycle, then samples the data at the next falling edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask : rd
endmodule : mesf_host_model
`default_nettype wire
